// file: include/ubp_map.svh
// Constants for the serial unit: register indices, field positions,
// reset values and framing counts.
// Assumes inclusion by bare name from the package and the design files.
`ifndef UBP_MAP_SVH
`define UBP_MAP_SVH

// Register word indices; byte address is four times the index
`define UBP_IDX_MODE      16'hff70
`define UBP_IDX_STATUS    16'hff71
`define UBP_IDX_BAUD      16'hff73
`define UBP_IDX_DATA      16'hff74

// Wishbone word address slice and unused upper bits
`define UBP_ADR_TOP       17
`define UBP_ADR_LO        2
`define UBP_ADR_HI_ZERO   14'h0000

// Reset values
`define UBP_MODE_RESET    8'h00
`define UBP_STATUS_RESET  3'h0
`define UBP_BAUD_RESET    4'h0

// Mode register fields
`define UBP_MODE_TXE      7
`define UBP_MODE_RXE      6
`define UBP_MODE_PAR_HI   5
`define UBP_MODE_PAR_LO   4
`define UBP_MODE_CL       3
`define UBP_MODE_SL       2
`define UBP_MODE_WMASK    8'hfc

// Status register fields
`define UBP_ST_PE         2
`define UBP_ST_FE         1
`define UBP_ST_OVE        0

// Baud control field and source codes
`define UBP_BAUD_HI       7
`define UBP_BAUD_LO       4
`define UBP_SEL_INT_MAX   4'h7
`define UBP_SEL_EXT       4'h8

// Parity mode codes
`define UBP_PAR_NONE      2'b00
`define UBP_PAR_ZERO      2'b01
`define UBP_PAR_ODD       2'b10
`define UBP_PAR_EVEN      2'b11

// Framing counts
`define UBP_CHAR_LONG     4'h8
`define UBP_CHAR_SHORT    4'h7
`define UBP_ONE_BIT       4'h1
`define UBP_TWO_BITS      4'h2
`define UBP_RX_SHIFT_W    4'ha
`define UBP_FRAME_IDLE    12'hfff
`define UBP_HALF_LAST     4'h7
`define UBP_BIT_LAST      4'hf

`endif

// file: include/ubp_pkg.sv
// Types and framing functions shared by both ends of the serial link.
// Assumes the constant header is on the include path.
`include "ubp_map.svh"

package ubp_pkg;

    // Two-bit parity mode
    typedef logic [1:0] ubp_par_t;

    // Receiver sequence
    typedef enum logic [1:0] {UBP_RX_IDLE, UBP_RX_START, UBP_RX_BITS}
        ubp_rx_t;

    // Parity bit to send for masked data
    function automatic logic ubp_par_gen(input logic [7:0] d,
                                         input ubp_par_t   m);
        logic r;
        r = 1'b0;
        if (m == `UBP_PAR_EVEN) begin
            r = ^d;
        end else if (m == `UBP_PAR_ODD) begin
            r = ~^d;
        end
        return r;
    endfunction : ubp_par_gen

    // Parity error for received data plus parity bit
    function automatic logic ubp_par_err(input logic [7:0] d,
                                         input logic       p,
                                         input ubp_par_t   m);
        logic r;
        r = 1'b0;
        if (m == `UBP_PAR_EVEN) begin
            r = ^{d, p};
        end else if (m == `UBP_PAR_ODD) begin
            r = ~^{d, p};
        end
        return r;
    endfunction : ubp_par_err

    // Whole frame, LSB first, idle ones fill the stop bits
    function automatic logic [11:0] ubp_frame(input logic [7:0] d,
                                              input ubp_par_t   m,
                                              input logic       cl);
        logic [11:0] f;
        logic [7:0]  dm;
        dm = cl ? d : {1'b0, d[6:0]};
        f = `UBP_FRAME_IDLE;
        f[0] = 1'b0;
        if (cl) begin
            f[8:1] = dm;
        end else begin
            f[7:1] = dm[6:0];
        end
        if (m != `UBP_PAR_NONE) begin
            f[cl ? 9 : 8] = ubp_par_gen(dm, m);
        end
        return f;
    endfunction : ubp_frame

    // Transmitted bit count including start and stop bits
    function automatic logic [3:0] ubp_tx_len(input ubp_par_t m,
                                              input logic     cl,
                                              input logic     sl);
        return `UBP_ONE_BIT + (cl ? `UBP_CHAR_LONG : `UBP_CHAR_SHORT)
             + {3'h0, m != `UBP_PAR_NONE}
             + (sl ? `UBP_TWO_BITS : `UBP_ONE_BIT);
    endfunction : ubp_tx_len

    // Received bit count after the start bit: one stop bit only
    function automatic logic [3:0] ubp_rx_len(input ubp_par_t m,
                                              input logic     cl);
        return (cl ? `UBP_CHAR_LONG : `UBP_CHAR_SHORT)
             + {3'h0, m != `UBP_PAR_NONE} + `UBP_ONE_BIT;
    endfunction : ubp_rx_len

    // Decode collected bits into {parity err, framing err, data}
    function automatic logic [9:0] ubp_rx_decode(input logic [9:0] sh,
                                                 input ubp_par_t   m,
                                                 input logic       cl,
                                                 input logic [3:0] n);
        logic [9:0] al;
        logic [7:0] dm;
        logic       p;
        logic       stop;
        al = sh >> (`UBP_RX_SHIFT_W - n);
        dm = cl ? al[7:0] : {1'b0, al[6:0]};
        p = cl ? al[8] : al[7];
        stop = al[n - `UBP_ONE_BIT];
        return {ubp_par_err(dm, p, m), ~stop, dm};
    endfunction : ubp_rx_decode

endpackage : ubp_pkg

// file: include/ubp_link_if.sv
// Serial link between the device end and the remote end.
// Assumes both ends run on the same clock; lines idle high.
`timescale 1ns/1ps
`default_nettype none

interface ubp_link_if;
    logic dev_to_rem;      // Device transmit line
    logic rem_to_dev;      // Device receive line
    logic ext_baud_clock;  // External baud clock pin, made by the remote

    modport dev (output dev_to_rem, input rem_to_dev, input ext_baud_clock);
    modport rem (input dev_to_rem, output rem_to_dev, output ext_baud_clock);
endinterface : ubp_link_if

`default_nettype wire

// file: core/ubp_device.sv
// Serial unit device end: mode, status, baud and data registers on a
// classic Wishbone slave, baud generator, transmitter and receiver.
// Assumes link inputs synchronous to mclk_in except the baud clock pin.
//
// Overview of operation
// - Read-only status, reset zero, bits 7-3 zero
// - Bit 2 flags received parity mismatch
// - Bit 1 flags missing stop bit
// - Bit 0 flags reception before buffer read
// - Receiver checks one stop bit only
// - Unread buffer flags overrun on every reception
// - Baud control: select bits 7-4, rest zero
// - Codes 0-7 give clock over 2^(code+1)
// - Code 8 selects external pin; others prohibited
// - Software never rewrites baud control mid-transfer
// - Internal bit rate is clock/2^(n+1)/16
// - External bit rate is pin frequency/16
// - Software avoids n=1 at 5 MHz
// - Start, 7/8 data, optional parity, 1/2 stops
// - Seven-bit mode drops/zeroes data bit 7
// - Even parity sends ones-count odd as 1
// - Even parity: odd total means error
// - Odd parity sends ones-count odd as 0
// - Odd parity: even total means error
// - Parity modes: none, zero, odd, even
// - Length bits: 7/8 data, 1/2 stops
// - Buffer read or next frame clears flags
//
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ubp_map.svh"

module ubp_device (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    // Wishbone slave
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [31:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    // Serial link
    ubp_link_if.dev          link
);

    // Register state
    logic [7:0]       mode_q;      // Mode bits 7..2, low bits kept zero
    logic [3:0]       sel_q;       // Baud source select
    logic [2:0]       status_q;    // Parity, framing, overrun flags
    logic [7:0]       rxbuf_q;     // Receive buffer
    logic             rxfull_q;    // Buffer holds unread data
    logic             ack_q;       // Bus answer
    logic [31:0]      dat_q;       // Registered read data

    // Baud generator state
    logic [7:0]       div_q;       // Free running divider
    logic [2:0]       ext_q;       // Pin synchroniser and edge stage

    // Transmitter and receiver state
    logic [11:0]      tsh_q;       // Frame shift, bit 0 is the line
    logic [3:0]       tcnt_q;      // Bits left to send
    logic [3:0]       tph_q;       // Tick phase within a bit
    ubp_pkg::ubp_rx_t rst_q;       // Receiver sequence
    logic [3:0]       rph_q;       // Tick phase within a bit
    logic [3:0]       rcnt_q;      // Bits collected
    logic [9:0]       rsh_q;       // Collected bits

    // Mode fields
    wire              txe   = mode_q[`UBP_MODE_TXE];
    wire              rxe   = mode_q[`UBP_MODE_RXE];
    wire ubp_pkg::ubp_par_t par =
        mode_q[`UBP_MODE_PAR_HI:`UBP_MODE_PAR_LO];
    wire              cl    = mode_q[`UBP_MODE_CL];
    wire              sl    = mode_q[`UBP_MODE_SL];
    wire              tx_busy = tcnt_q != 4'h0;

    // Bus decode
    wire [15:0] idx      = wb_adr_in[`UBP_ADR_TOP:`UBP_ADR_LO];
    wire        hi_ok    = wb_adr_in[31:`UBP_ADR_TOP+1] == `UBP_ADR_HI_ZERO;
    wire        hit_mode = hi_ok && idx == `UBP_IDX_MODE;
    wire        hit_st   = hi_ok && idx == `UBP_IDX_STATUS;
    wire        hit_baud = hi_ok && idx == `UBP_IDX_BAUD;
    wire        hit_data = hi_ok && idx == `UBP_IDX_DATA;
    wire        req      = wb_cyc_in & wb_stb_in;
    // Writes and read side effects act at the edge where ack is seen
    wire        commit   = req & ack_q;
    wire        wr       = commit & wb_we_in & wb_sel_in[0];
    wire        rd_buf   = commit & ~wb_we_in & hit_data;

    // Read selection; unmapped words read zero
    wire [7:0] rd_mux =
        hit_mode ? {mode_q[7:2], 1'b0, tx_busy} :
        hit_st   ? {5'h00, status_q} :
        hit_baud ? {sel_q, 4'h0} :
        hit_data ? rxbuf_q : 8'h00;

    // Baud tick: internal divider or synchronised pin edge
    wire [7:0] int_mask = 8'((9'h002 << sel_q) - 9'h001);
    wire       int_tick = sel_q <= `UBP_SEL_INT_MAX &&
                          (div_q & int_mask) == int_mask;
    wire       ext_rise = ext_q[1] & ~ext_q[2];
    // Prohibited codes give no tick at all
    wire       tick = (sel_q == `UBP_SEL_EXT) ? ext_rise : int_tick;

    // Transmit load and frame
    wire        tx_load  = wr & hit_data & txe & ~tx_busy;
    wire [11:0] tx_frame =
        ubp_pkg::ubp_frame(wb_dat_in[7:0], par, cl);
    wire [3:0]  tx_len   = ubp_pkg::ubp_tx_len(par, cl, sl);

    // Receive completion and decode
    wire       rxd      = link.rem_to_dev;
    wire [3:0] rx_len   = ubp_pkg::ubp_rx_len(par, cl);
    wire [9:0] rsh_next = {rxd, rsh_q[9:1]};
    wire       rx_done  = rxe && rst_q == ubp_pkg::UBP_RX_BITS && tick &&
                          rph_q == `UBP_BIT_LAST &&
                          rcnt_q == rx_len - `UBP_ONE_BIT;
    wire [9:0] rx_dec   =
        ubp_pkg::ubp_rx_decode(rsh_next, par, cl, rx_len);

    assign wb_ack_out      = ack_q;
    assign wb_dat_out      = dat_q;
    assign link.dev_to_rem = tsh_q[0];

    // Bus answer one cycle after the request, dropped the cycle after
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q) begin
                dat_q <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Mode and baud control registers
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mode_q <= `UBP_MODE_RESET;
            sel_q  <= `UBP_BAUD_RESET;
        end else begin
            if (wr & hit_mode) begin
                mode_q <= wb_dat_in[7:0] & `UBP_MODE_WMASK;
            end
            // Rewriting mid-transfer upsets the rate; software avoids it
            if (wr & hit_baud) begin
                sel_q <= wb_dat_in[`UBP_BAUD_HI:`UBP_BAUD_LO];
            end
        end
    end

    // Divider and pin synchroniser; only stage 1 reads stage 0
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q <= 8'h00;
            ext_q <= 3'h0;
        end else begin
            div_q <= div_q + 8'h01;
            ext_q <= {ext_q[1:0], link.ext_baud_clock};
        end
    end

    // Transmitter: sixteen ticks per bit, ones shifted in behind
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tsh_q  <= `UBP_FRAME_IDLE;
            tcnt_q <= 4'h0;
            tph_q  <= 4'h0;
        end else if (!txe) begin
            tsh_q  <= `UBP_FRAME_IDLE;
            tcnt_q <= 4'h0;
        end else if (tx_load) begin
            tsh_q  <= tx_frame;
            tcnt_q <= tx_len;
            tph_q  <= 4'h0;
        end else if (tx_busy && tick) begin
            tph_q <= tph_q + 4'h1;
            if (tph_q == `UBP_BIT_LAST) begin
                tsh_q  <= {1'b1, tsh_q[11:1]};
                tcnt_q <= tcnt_q - 4'h1;
            end
        end
    end

    // Receiver: confirm start at half a bit, then sample each bit centre
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_q  <= ubp_pkg::UBP_RX_IDLE;
            rph_q  <= 4'h0;
            rcnt_q <= 4'h0;
            rsh_q  <= 10'h000;
        end else if (!rxe) begin
            // Disabling aborts at once; buffer and flags stay
            rst_q <= ubp_pkg::UBP_RX_IDLE;
        end else begin
            unique case (rst_q)
                ubp_pkg::UBP_RX_IDLE: begin
                    if (!rxd) begin
                        rst_q <= ubp_pkg::UBP_RX_START;
                        rph_q <= 4'h0;
                    end
                end
                ubp_pkg::UBP_RX_START: begin
                    if (tick) begin
                        rph_q <= rph_q + 4'h1;
                        if (rph_q == `UBP_HALF_LAST) begin
                            // A glitch shorter than half a bit is dropped
                            rst_q  <= rxd ? ubp_pkg::UBP_RX_IDLE
                                          : ubp_pkg::UBP_RX_BITS;
                            rph_q  <= 4'h0;
                            rcnt_q <= 4'h0;
                        end
                    end
                end
                ubp_pkg::UBP_RX_BITS: begin
                    if (tick) begin
                        rph_q <= rph_q + 4'h1;
                        if (rph_q == `UBP_BIT_LAST) begin
                            rsh_q  <= rsh_next;
                            rcnt_q <= rcnt_q + 4'h1;
                            if (rx_done) begin
                                rst_q <= ubp_pkg::UBP_RX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    // Buffer and flags; a frame landing with a read wins over the clear
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_q <= `UBP_STATUS_RESET;
            rxbuf_q  <= 8'h00;
            rxfull_q <= 1'b0;
        end else if (rx_done) begin
            rxbuf_q  <= rx_dec[7:0];
            status_q[`UBP_ST_PE]  <= rx_dec[9];
            status_q[`UBP_ST_FE]  <= rx_dec[8];
            status_q[`UBP_ST_OVE] <= rxfull_q & ~rd_buf;
            rxfull_q <= 1'b1;
        end else if (rd_buf) begin
            status_q <= `UBP_STATUS_RESET;
            rxfull_q <= 1'b0;
        end
    end

endmodule : ubp_device

`default_nettype wire

// file: core/ubp_remote.sv
// Remote serial end: transmitter, receiver with parity and stop check,
// and a divider that drives the external baud clock pin.
// Assumes the device runs at the same bit time as BIT_CYCLES.
`timescale 1ns/1ps
`default_nettype none
`include "ubp_map.svh"

module ubp_remote #(
    parameter int BIT_CYCLES = 128,   // Clock cycles per bit
    parameter int EXT_HALF   = 4      // Half period of the baud pin
) (
    // Clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    // Frame format
    input  wire logic [1:0] cfg_par_in,
    input  wire logic       cfg_cl_in,
    input  wire logic       cfg_sl_in,
    // Transmit request
    input  wire logic       tx_valid_in,
    input  wire logic [7:0] tx_data_in,
    output logic            tx_ready_out,
    // Receive result
    output logic            rx_valid_out,
    output logic [7:0]      rx_data_out,
    output logic            rx_pe_out,
    output logic            rx_fe_out,
    // Serial link
    ubp_link_if.rem         link
);

    // Counters are sixteen bits wide
    if (BIT_CYCLES < 2 || BIT_CYCLES > 65535 ||
        EXT_HALF < 1 || EXT_HALF > 65535) begin : g_bad_cfg
        $error("ubp_remote: bad BIT_CYCLES or EXT_HALF");
    end

    localparam logic [15:0] BIT_LAST  = 16'(BIT_CYCLES - 1);
    localparam logic [15:0] HALF_LAST = 16'(BIT_CYCLES / 2 - 1);
    localparam logic [15:0] EXT_LAST  = 16'(EXT_HALF - 1);

    // State
    logic [15:0]      ediv_q;      // Baud pin divider
    logic             eclk_q;      // Baud pin level
    logic [11:0]      tsh_q;       // Frame shift, bit 0 is the line
    logic [3:0]       tcnt_q;      // Bits left to send
    logic [15:0]      tph_q;       // Cycle phase within a bit
    ubp_pkg::ubp_rx_t rst_q;       // Receiver sequence
    logic [15:0]      rph_q;       // Cycle phase within a bit
    logic [3:0]       rcnt_q;      // Bits collected
    logic [9:0]       rsh_q;       // Collected bits

    wire       rxd      = link.dev_to_rem;
    wire       tx_busy  = tcnt_q != 4'h0;
    wire [3:0] rx_len   = ubp_pkg::ubp_rx_len(cfg_par_in, cfg_cl_in);
    wire [9:0] rsh_next = {rxd, rsh_q[9:1]};
    wire       bit_end  = rph_q == BIT_LAST;
    wire       rx_done  = rst_q == ubp_pkg::UBP_RX_BITS && bit_end &&
                          rcnt_q == rx_len - `UBP_ONE_BIT;
    wire [9:0] rx_dec   =
        ubp_pkg::ubp_rx_decode(rsh_next, cfg_par_in, cfg_cl_in, rx_len);

    assign tx_ready_out        = ~tx_busy;
    assign link.rem_to_dev     = tsh_q[0];
    assign link.ext_baud_clock = eclk_q;

    // Baud pin divider, free running
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ediv_q <= 16'h0000;
            eclk_q <= 1'b0;
        end else if (ediv_q == EXT_LAST) begin
            ediv_q <= 16'h0000;
            eclk_q <= ~eclk_q;
        end else begin
            ediv_q <= ediv_q + 16'h0001;
        end
    end

    // Transmitter; a new frame is taken only when idle
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tsh_q  <= `UBP_FRAME_IDLE;
            tcnt_q <= 4'h0;
            tph_q  <= 16'h0000;
        end else if (tx_valid_in && !tx_busy) begin
            tsh_q  <= ubp_pkg::ubp_frame(tx_data_in, cfg_par_in, cfg_cl_in);
            tcnt_q <= ubp_pkg::ubp_tx_len(cfg_par_in, cfg_cl_in, cfg_sl_in);
            tph_q  <= 16'h0000;
        end else if (tx_busy) begin
            tph_q <= (tph_q == BIT_LAST) ? 16'h0000 : tph_q + 16'h0001;
            if (tph_q == BIT_LAST) begin
                tsh_q  <= {1'b1, tsh_q[11:1]};
                tcnt_q <= tcnt_q - 4'h1;
            end
        end
    end

    // Receiver: confirm start at half a bit, then sample bit centres
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_q  <= ubp_pkg::UBP_RX_IDLE;
            rph_q  <= 16'h0000;
            rcnt_q <= 4'h0;
            rsh_q  <= 10'h000;
        end else begin
            unique case (rst_q)
                ubp_pkg::UBP_RX_IDLE: begin
                    rph_q <= 16'h0000;
                    if (!rxd) begin
                        rst_q <= ubp_pkg::UBP_RX_START;
                    end
                end
                ubp_pkg::UBP_RX_START: begin
                    rph_q <= rph_q + 16'h0001;
                    if (rph_q == HALF_LAST) begin
                        rst_q  <= rxd ? ubp_pkg::UBP_RX_IDLE
                                      : ubp_pkg::UBP_RX_BITS;
                        rph_q  <= 16'h0000;
                        rcnt_q <= 4'h0;
                    end
                end
                ubp_pkg::UBP_RX_BITS: begin
                    rph_q <= bit_end ? 16'h0000 : rph_q + 16'h0001;
                    if (bit_end) begin
                        rsh_q  <= rsh_next;
                        rcnt_q <= rcnt_q + 4'h1;
                        if (rx_done) begin
                            rst_q <= ubp_pkg::UBP_RX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Registered receive result with a one-cycle valid pulse
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rx_valid_out <= 1'b0;
            rx_data_out  <= 8'h00;
            rx_pe_out    <= 1'b0;
            rx_fe_out    <= 1'b0;
        end else begin
            rx_valid_out <= rx_done;
            if (rx_done) begin
                rx_data_out <= rx_dec[7:0];
                rx_pe_out   <= rx_dec[9];
                rx_fe_out   <= rx_dec[8];
            end
        end
    end

endmodule : ubp_remote

`default_nettype wire

// file: sim/ubp_chk.sv
// Link checker: bit lengths, stop level and idle level of both lines.
// Assumes 32-clock bits and a baud pin that toggles every clock.
`timescale 1ns/1ps
`default_nettype none
module ubp_chk (
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic dev_to_rem,
    input wire logic rem_to_dev,
    input wire logic ext_baud_clock
);
    logic [9:0] dlo_q; // Cycles the device line has been low
    logic [9:0] rlo_q; // Cycles the remote line has been low
    // Low-run counters; a run is judged on the edge where it ends
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            dlo_q <= 10'h000;
            rlo_q <= 10'h000;
        end else begin
            dlo_q <= dev_to_rem ? 10'h000 : dlo_q + 10'h001;
            rlo_q <= rem_to_dev ? 10'h000 : rlo_q + 10'h001;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // A high bit lasts a whole bit, so at least eight clocks
    sequence s_hold_hi(s); s [*8]; endsequence
    idle_high_a: assert property ($rose(reset_n_in) |-> dev_to_rem && rem_to_dev)
        else $error("line low after reset");
    dev_len_a: assert property ($rose(dev_to_rem) |-> dlo_q >= 10'h01e && dlo_q <= 10'h160)
        else $error("device low run length");
    rem_len_a: assert property ($rose(rem_to_dev) |-> rlo_q[4:0] == 5'h00 && rlo_q <= 10'h140)
        else $error("remote low run length");
    dev_max_a: assert property (dlo_q <= 10'h160)
        else $error("device line stuck low");
    rem_max_a: assert property (rlo_q <= 10'h140)
        else $error("remote line stuck low");
    dev_stop_a: assert property ($rose(dev_to_rem) |-> s_hold_hi(dev_to_rem))
        else $error("device high bit short");
    rem_stop_a: assert property ($rose(rem_to_dev) |-> s_hold_hi(rem_to_dev))
        else $error("remote high bit short");
    ext_tgl_a: assert property ($changed(ext_baud_clock) |=> $changed(ext_baud_clock))
        else $error("baud pin period");
endmodule : ubp_chk
`default_nettype wire

// file: sim/tb.sv
// Bench: device and remote on one link, registers over classic Wishbone.
// Assumes sel 0 and the baud pin both give 32-clock bits.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
    err_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module tb;
    logic mclk_in = 1'b0, reset_n_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic tv = 1'b0, rcl = 1'b1, rsl = 1'b0, ack, tr, rv, rpe, rfe;
    logic [31:0] adr = 32'h0, wd = 32'h0, rdat, q;
    logic [3:0]  sel = 4'h0;
    logic [1:0]  rpar = 2'h0;
    logic [7:0]  td = 8'h00, rd8;
    int          err_count = 0, n_checks = 0, cyc_n = 0;
    ubp_link_if link ();
    ubp_device i_ubp_device (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(sel), .wb_dat_in(wd), .wb_dat_out(rdat),
        .wb_ack_out(ack), .link(link));
    ubp_remote #(.BIT_CYCLES(32), .EXT_HALF(1)) i_ubp_remote (
        .mclk_in(mclk_in), .reset_n_in(reset_n_in), .cfg_par_in(rpar),
        .cfg_cl_in(rcl), .cfg_sl_in(rsl), .tx_valid_in(tv), .tx_data_in(td),
        .tx_ready_out(tr), .rx_valid_out(rv), .rx_data_out(rd8),
        .rx_pe_out(rpe), .rx_fe_out(rfe), .link(link));
    ubp_chk chk (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
        .dev_to_rem(link.dev_to_rem), .rem_to_dev(link.rem_to_dev),
        .ext_baud_clock(link.ext_baud_clock));
    initial forever #2.5 mclk_in = ~mclk_in;
    // Hang guard: over three times the expected run
    always @(posedge mclk_in) begin
        cyc_n++;
        if (cyc_n == 20000) begin
            err_count++;
            tally_and_finish;
        end
    end
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : tally_and_finish
    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d);
        @(posedge mclk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'h1;
        adr <= {14'h0000, idx, 2'b00};
        wd <= {24'h000000, d};
        do @(posedge mclk_in); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [15:0] idx, input logic [7:0] e, input string m);
        wb(1'b0, idx, 8'h00);
        `CHK(q, {24'h000000, e}, m)
    endtask : rd
    // Device mode, remote format follows the same bits
    task automatic fmt(input logic [7:0] mode);
        rpar <= mode[5:4];
        rcl <= mode[3];
        rsl <= mode[2];
        wb(1'b1, 16'hff70, mode);
    endtask : fmt
    // Device sends d once idle; remote must receive e with no error
    task automatic dev_tx(input logic [7:0] d, input logic [7:0] e);
        do wb(1'b0, 16'hff70, 8'h00); while (q[0]);
        wb(1'b1, 16'hff74, d);
        do @(posedge mclk_in); while (rv !== 1'b1);
        `CHK({rfe, rpe, rd8}, {2'b00, e}, "frame to remote")
    endtask : dev_tx
    // Remote sends d and finishes its last stop bit
    task automatic rem_tx(input logic [7:0] d);
        @(posedge mclk_in);
        tv <= 1'b1;
        td <= d;
        do @(posedge mclk_in); while (tr !== 1'b1);
        tv <= 1'b0;
        @(posedge mclk_in);
        do @(posedge mclk_in); while (tr !== 1'b1);
    endtask : rem_tx
    initial begin
        repeat (20) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        rd(16'hff71, 8'h00, "status reset");
        rd(16'hff73, 8'h00, "baud reset");
        wb(1'b1, 16'hff73, 8'h7f);
        rd(16'hff73, 8'h70, "baud low bits");
        wb(1'b1, 16'hff71, 8'hff);
        rd(16'hff71, 8'h00, "status write");
        rd(16'hff72, 8'h00, "unmapped");
        wb(1'b1, 16'hff73, 8'h00);
        // Every parity mode with both lengths, two stops sent
        for (int i = 0; i < 8; i++) begin
            fmt({2'b11, i[1:0], i[2], 3'b100});
            dev_tx(8'h96, {i[2], 7'h16});
        end
        fmt(8'hfc);
        rsl <= 1'b0;
        rem_tx(8'h5a);
        rd(16'hff71, 8'h00, "one stop");
        rd(16'hff74, 8'h5a, "rx data");
        rpar <= 2'b10;
        rem_tx(8'h5a);
        rd(16'hff71, 8'h04, "even parity err");
        rd(16'hff74, 8'h5a, "rx data");
        rd(16'hff71, 8'h00, "read clears");
        fmt(8'he8);
        rpar <= 2'b11;
        rem_tx(8'h33);
        rd(16'hff71, 8'h04, "odd parity err");
        rpar <= 2'b10;
        rem_tx(8'h33);
        rd(16'hff71, 8'h01, "overrun");
        rem_tx(8'h33);
        rd(16'hff71, 8'h01, "overrun again");
        rd(16'hff74, 8'h33, "rx data");
        fmt(8'hc0);
        rcl <= 1'b1;
        rem_tx(8'h80);
        rd(16'hff74, 8'h00, "seven bit rx");
        rem_tx(8'h00);
        rd(16'hff71, 8'h02, "framing err");
        wb(1'b1, 16'hff73, 8'h80);
        fmt(8'hf8);
        dev_tx(8'ha5, 8'ha5);
        tally_and_finish;
    end
endmodule : tb
`default_nettype wire
